// ---- core/plc_consts.vh ----
// Register map, field layout, reset values and timing counts of the loop controller
`ifndef PLC_CONSTS_VH
`define PLC_CONSTS_VH

// ==========================================================
// Register offsets (byte addresses)
`define PLC_ADDR_CTRL      8'h00
`define PLC_ADDR_SET       8'h04
`define PLC_ADDR_GAIN      8'h08
`define PLC_ADDR_REFW      8'h0c
`define PLC_ADDR_ISPAN     8'h10
`define PLC_ADDR_DSPAN     8'h14
`define PLC_ADDR_AWGAIN    8'h18
`define PLC_ADDR_BIAS      8'h1c
`define PLC_ADDR_UPPER     8'h20
`define PLC_ADDR_LOWER     8'h24
`define PLC_ADDR_MANUAL    8'h28
`define PLC_ADDR_INTERVAL  8'h2c
`define PLC_ADDR_STATUS    8'h30
`define PLC_ADDR_OUTPUT    8'h34
`define PLC_ADDR_PV        8'h38

// ==========================================================
// Control field positions and mode codes
`define PLC_CTRL_RUN       0
`define PLC_CTRL_MODE_LO   1
`define PLC_CTRL_MODE_HI   2
`define PLC_CTRL_REVERSE   3
`define PLC_CTRL_MANUAL    4
`define PLC_MODE_P         2'h0
`define PLC_MODE_PI        2'h1
`define PLC_MODE_PID       2'h2
`define PLC_MODE_ONOFF     2'h3

// ==========================================================
// Reset values and spans
`define PLC_FULL_SCALE     16'h0fa0
`define PLC_INTERVAL_MAX   8'h64
`define PLC_RST_GAIN       16'h0100
`define PLC_RST_REFW       16'h0100
`define PLC_RST_INTERVAL   8'h0a
`define PLC_DIV_STEPS      5'h18

// ==========================================================
// Timing: one tenth of a second at the system clock
`define PLC_TENTH_NS       100000000
`define PLC_CLK_NS         10
`define PLC_TENTH_CYCLES   (`PLC_TENTH_NS / `PLC_CLK_NS)

`endif

// ---- core/plc_core.v ----
// Sampled PID loop controller with APB register slave
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "plc_consts.vh"

module plc_core #(
  parameter TENTH_CYCLES = `PLC_TENTH_CYCLES,
  parameter CNT_W        = 27
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [15:0] present_value,
  output reg  [15:0] manipulated_output,
  output reg         output_strobe
);

  // ==========================================================
  // Configuration registers
  reg  [4:0]  ctrl_q;
  reg  [15:0] set_value_q;
  reg  [15:0] proportional_gain_q;
  reg  [15:0] ref_weight_q;
  reg  [15:0] integral_span_q;
  reg  [15:0] derivative_span_q;
  reg  [15:0] windup_gain_q;
  reg  [15:0] bias_q;
  reg  [15:0] output_upper_limit_q;
  reg  [15:0] output_lower_limit_q;
  reg  [15:0] manual_value_q;
  reg  [7:0]  interval_q;

  // ==========================================================
  // Loop state
  localparam S_IDLE = 2'h0;
  localparam S_DIV  = 2'h1;
  localparam S_CALC = 2'h2;
  localparam S_SAT  = 2'h3;

  reg  [1:0]        state_q;
  reg  [CNT_W-1:0]  tick_cnt_q;
  reg  [7:0]        tenth_cnt_q;
  reg  [15:0]       pv_q;
  reg  [23:0]       quo_q;
  reg  [16:0]       rem_q;
  reg  [4:0]        div_cnt_q;
  reg  signed [63:0] mv_raw_q;
  reg  signed [63:0] i_acc_q;
  reg  signed [63:0] e_old_q;
  reg               saturated_q;

  wire        run     = ctrl_q[`PLC_CTRL_RUN];
  wire [1:0]  mode    = ctrl_q[`PLC_CTRL_MODE_HI:`PLC_CTRL_MODE_LO];
  wire        reverse = ctrl_q[`PLC_CTRL_REVERSE];
  wire        manual  = ctrl_q[`PLC_CTRL_MANUAL];

  // ==========================================================
  // Sample timer
  wire        tick       = (tick_cnt_q == TENTH_CYCLES[CNT_W-1:0] - 1'b1);
  wire [7:0]  interval_e = (interval_q == 8'h00) ? 8'h01 : interval_q;
  wire        sample_due = run && tick && (tenth_cnt_q >= interval_e - 8'h01);

  always @(posedge clk) begin
    if (srst || !run) begin
      tick_cnt_q  <= {CNT_W{1'b0}};
      tenth_cnt_q <= 8'h00;
    end else if (tick) begin
      tick_cnt_q <= {CNT_W{1'b0}};
      if (sample_due)
        tenth_cnt_q <= 8'h00;
      else
        tenth_cnt_q <= tenth_cnt_q + 8'h01;
    end else begin
      tick_cnt_q <= tick_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // Arithmetic; gains and reference weight are unsigned 8.8 fixed point
  wire signed [63:0] sv_w   = {48'h0, set_value_q};
  wire signed [63:0] pv_w   = {48'h0, pv_q};
  wire signed [63:0] kp_w   = {48'h0, proportional_gain_q};
  wire signed [63:0] b_w    = {48'h0, ref_weight_q};
  wire signed [63:0] td_w   = {48'h0, derivative_span_q};
  wire signed [63:0] a0_w   = {48'h0, windup_gain_q};
  wire signed [63:0] bi_w   = {40'h0, quo_q};
  wire signed [63:0] bias_w = {{48{bias_q[15]}}, bias_q};

  wire signed [63:0] bsv    = (b_w * sv_w) >>> 8;
  wire signed [63:0] ep_raw = bsv - pv_w;
  wire signed [63:0] e_raw  = sv_w - pv_w;
  wire signed [63:0] ep     = reverse ? -ep_raw : ep_raw;
  wire signed [63:0] e      = reverse ? -e_raw : e_raw;

  wire signed [63:0] p_term = (kp_w * ep) >>> 8;
  wire signed [63:0] d_term = (kp_w * td_w * (e - e_old_q)) >>> 8;
  wire signed [63:0] i_term = i_acc_q >>> 16;
  wire               use_i  = (mode == `PLC_MODE_PI) || (mode == `PLC_MODE_PID);

  wire signed [63:0] mv_sum = p_term
                            + (use_i ? i_term : 64'sh0)
                            + ((mode == `PLC_MODE_PID) ? d_term : 64'sh0)
                            + bias_w;

  // Limits folded into the full span so a bad pair still yields a legal output
  wire [15:0] hi_lim = (output_upper_limit_q > `PLC_FULL_SCALE) ? `PLC_FULL_SCALE : output_upper_limit_q;
  wire [15:0] lo_lim = (output_lower_limit_q > hi_lim) ? hi_lim : output_lower_limit_q;
  wire signed [63:0] hi_w = {48'h0, hi_lim};
  wire signed [63:0] lo_w = {48'h0, lo_lim};

  wire signed [63:0] u_w = (mv_raw_q < lo_w) ? lo_w :
                           (mv_raw_q > hi_w) ? hi_w : mv_raw_q;
  wire [15:0] manual_lim = (manual_value_q > `PLC_FULL_SCALE) ? `PLC_FULL_SCALE : manual_value_q;

  reg  [15:0] out_d;
  always @* begin
    if (manual)
      out_d = manual_lim;
    else if (mode == `PLC_MODE_ONOFF)
      out_d = (e > 64'sh0) ? hi_lim : lo_lim;
    else
      out_d = u_w[15:0];
  end

  // Integral gain = gain / span, 16 fractional bits; division is serial to save area
  wire [16:0] rem_sh  = {rem_q[15:0], quo_q[23]};
  wire        sub_ok  = (rem_sh >= {1'b0, integral_span_q});
  wire signed [63:0] i_next = i_acc_q + bi_w * e + ((a0_w * (u_w - mv_raw_q)) <<< 8);

  // ==========================================================
  // Sample sequence
  always @(posedge clk) begin
    if (srst) begin
      state_q            <= S_IDLE;
      pv_q               <= 16'h0000;
      quo_q              <= 24'h000000;
      rem_q              <= 17'h00000;
      div_cnt_q          <= 5'h00;
      mv_raw_q           <= 64'sh0;
      i_acc_q            <= 64'sh0;
      e_old_q            <= 64'sh0;
      saturated_q        <= 1'b0;
      manipulated_output <= 16'h0000;
      output_strobe      <= 1'b0;
    end else begin
      output_strobe <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (sample_due) begin
            pv_q      <= present_value;
            quo_q     <= {proportional_gain_q, 8'h00};
            rem_q     <= 17'h00000;
            div_cnt_q <= `PLC_DIV_STEPS;
            state_q   <= S_DIV;
          end
        end
        S_DIV: begin
          if (integral_span_q == 16'h0000) begin
            quo_q   <= 24'h000000;
            state_q <= S_CALC;
          end else begin
            rem_q     <= sub_ok ? (rem_sh - {1'b0, integral_span_q}) : rem_sh;
            quo_q     <= {quo_q[22:0], sub_ok};
            div_cnt_q <= div_cnt_q - 5'h01;
            if (div_cnt_q == 5'h01)
              state_q <= S_CALC;
          end
        end
        S_CALC: begin
          mv_raw_q <= mv_sum;
          state_q  <= S_SAT;
        end
        S_SAT: begin
          manipulated_output <= out_d;
          output_strobe      <= 1'b1;
          saturated_q        <= (mv_raw_q != u_w);
          if (use_i)
            i_acc_q <= i_next;
          else
            i_acc_q <= 64'sh0;
          e_old_q <= e;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // APB slave: one wait state, then pready with data or error
  wire access = psel && penable && !pready;
  wire commit = psel && penable && pready && pwrite;

  reg  [31:0] rd_mux;
  reg         hit;
  always @* begin
    hit    = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      `PLC_ADDR_CTRL:     rd_mux = {27'h0, ctrl_q};
      `PLC_ADDR_SET:      rd_mux = {16'h0, set_value_q};
      `PLC_ADDR_GAIN:     rd_mux = {16'h0, proportional_gain_q};
      `PLC_ADDR_REFW:     rd_mux = {16'h0, ref_weight_q};
      `PLC_ADDR_ISPAN:    rd_mux = {16'h0, integral_span_q};
      `PLC_ADDR_DSPAN:    rd_mux = {16'h0, derivative_span_q};
      `PLC_ADDR_AWGAIN:   rd_mux = {16'h0, windup_gain_q};
      `PLC_ADDR_BIAS:     rd_mux = {16'h0, bias_q};
      `PLC_ADDR_UPPER:    rd_mux = {16'h0, output_upper_limit_q};
      `PLC_ADDR_LOWER:    rd_mux = {16'h0, output_lower_limit_q};
      `PLC_ADDR_MANUAL:   rd_mux = {16'h0, manual_value_q};
      `PLC_ADDR_INTERVAL: rd_mux = {24'h0, interval_q};
      `PLC_ADDR_STATUS:   rd_mux = {29'h0, saturated_q, (state_q != S_IDLE), run};
      `PLC_ADDR_OUTPUT:   rd_mux = {16'h0, manipulated_output};
      `PLC_ADDR_PV:       rd_mux = {16'h0, pv_q};
      default:            hit = 1'b0;
    endcase
  end

  wire [15:0] wr16    = pwdata[15:0];
  wire [15:0] wr_lim  = (wr16 > `PLC_FULL_SCALE) ? `PLC_FULL_SCALE : wr16;
  wire [7:0]  wr_intv = (pwdata[31:8] != 24'h0 || pwdata[7:0] > `PLC_INTERVAL_MAX) ?
                        `PLC_INTERVAL_MAX : pwdata[7:0];

  always @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access;
      pslverr <= access && !hit;
      if (access)
        prdata <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      ctrl_q               <= 5'h00;
      set_value_q          <= 16'h0000;
      proportional_gain_q  <= `PLC_RST_GAIN;
      ref_weight_q         <= `PLC_RST_REFW;
      integral_span_q      <= 16'h0000;
      derivative_span_q    <= 16'h0000;
      windup_gain_q        <= 16'h0000;
      bias_q               <= 16'h0000;
      output_upper_limit_q <= `PLC_FULL_SCALE;
      output_lower_limit_q <= 16'h0000;
      manual_value_q       <= 16'h0000;
      interval_q           <= `PLC_RST_INTERVAL;
    end else if (commit) begin
      case (paddr)
        `PLC_ADDR_CTRL:     ctrl_q <= pwdata[4:0];
        `PLC_ADDR_SET:      set_value_q <= wr16;
        `PLC_ADDR_GAIN:     proportional_gain_q <= wr16;
        `PLC_ADDR_REFW:     ref_weight_q <= wr16;
        `PLC_ADDR_ISPAN:    integral_span_q <= wr16;
        `PLC_ADDR_DSPAN:    derivative_span_q <= wr16;
        `PLC_ADDR_AWGAIN:   windup_gain_q <= wr16;
        `PLC_ADDR_BIAS:     bias_q <= wr16;
        `PLC_ADDR_UPPER:    output_upper_limit_q <= wr_lim;
        `PLC_ADDR_LOWER:    output_lower_limit_q <= wr_lim;
        `PLC_ADDR_MANUAL:   manual_value_q <= wr_lim;
        `PLC_ADDR_INTERVAL: interval_q <= wr_intv;
        default: ;
      endcase
    end
  end

endmodule

// ---- tb/plc_core_assertions.sv ----
// Port checker for the loop controller
`timescale 1ns/1ps
`include "plc_consts.vh"
module plc_core_assertions #(
  parameter TENTH_CYCLES = 20,
  parameter CNT_W        = 27
) (
  input wire        clk,
  input wire        srst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [15:0] present_value,
  input wire [15:0] manipulated_output,
  input wire        output_strobe
);
  // ====
  // Limits shadowed from bus writes; lower above upper is not modelled
  wire [15:0] mv     = manipulated_output;
  wire        wr_hit = psel && penable && pready && pwrite;
  wire [15:0] wr_val = (pwdata[15:0] > `PLC_FULL_SCALE) ? `PLC_FULL_SCALE : pwdata[15:0];
  reg  [15:0] up_q;
  reg  [15:0] lo_q;
  reg  [4:0]  ctl_q;
  reg  [31:0] gap_q;
  always @(posedge clk) begin
    gap_q <= output_strobe ? 32'h1 : gap_q + 32'h1;
    if (srst) begin
      up_q  <= `PLC_FULL_SCALE;
      lo_q  <= 16'h0;
      ctl_q <= 5'h0;
      gap_q <= 32'h0;
    end else if (wr_hit) begin
      if (paddr == `PLC_ADDR_UPPER) up_q <= wr_val;
      if (paddr == `PLC_ADDR_LOWER) lo_q <= wr_val;
      if (paddr == `PLC_ADDR_CTRL) ctl_q <= pwdata[4:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_span; mv <= `PLC_FULL_SCALE; endproperty
  a_span: assert property (p_span) else $error("output above full scale");
  property p_limits; output_strobe && !ctl_q[4] |-> mv >= lo_q && mv <= up_q; endproperty
  a_limits: assert property (p_limits) else $error("output outside user limits");
  property p_onoff; output_strobe && ctl_q[4:1] == 4'h3 |-> mv == up_q || mv == lo_q; endproperty
  a_onoff: assert property (p_onoff) else $error("on off output not at a limit");
  property p_hold; !output_strobe |-> $stable(mv); endproperty
  a_hold: assert property (p_hold) else $error("output moved without strobe");
  property p_pulse; output_strobe |=> !output_strobe; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
  property p_gap; output_strobe |-> gap_q >= TENTH_CYCLES; endproperty
  a_gap: assert property (p_gap) else $error("outputs closer than one tick");
  property p_ready; psel && penable && !pready |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("bus answer late");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error without ready or with data");
endmodule
bind plc_core plc_core_assertions #(.TENTH_CYCLES(TENTH_CYCLES), .CNT_W(CNT_W)) u_chk (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .present_value(present_value),
  .manipulated_output(manipulated_output), .output_strobe(output_strobe));

// ---- tb/plc_plant.sv ----
// Sensor and actuator channel model
`timescale 1ns/1ps
module plc_plant (
  input  wire        clk,
  input  wire        srst,
  input  wire [15:0] level,
  input  wire [15:0] manipulated_output,
  input  wire        output_strobe,
  output reg  [15:0] present_value  = 16'h0,
  output reg         actuated       = 1'b0,
  output reg  [15:0] actuator_value = 16'h0
);
  // Sensor lags the process by one clock, as a real converter would
  always @(posedge clk) begin
    present_value  <= level;
    actuated       <= output_strobe && !srst;
    actuator_value <= manipulated_output;
  end
endmodule

// ---- tb/plc_core_tb_top.sv ----
// Self-checking bench for the loop controller
`timescale 1ns/1ps
`include "plc_consts.vh"
module plc_core_tb_top;
  localparam int TC = 60;
  logic        clk;
  logic        srst    = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [15:0] level   = 16'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [15:0] present_value;
  wire  [15:0] manipulated_output;
  wire         output_strobe;
  wire         actuated;
  wire  [15:0] actuator_value;
  logic [15:0] exp_q[$];
  logic [31:0] rd;
  logic        er;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          gap = 0;
  int          last_gap = 0;
  int          sv, pv, bias, ivl;
  logic [7:0]  ra [8] = '{`PLC_ADDR_CTRL, `PLC_ADDR_GAIN, `PLC_ADDR_REFW, `PLC_ADDR_UPPER,
                          `PLC_ADDR_LOWER, `PLC_ADDR_INTERVAL, `PLC_ADDR_BIAS, 8'h3c};
  logic [31:0] rv [8] = '{32'h0, 32'h100, 32'h100, 32'hfa0, 32'h0, 32'ha, 32'h0, 32'h0};
  plc_core #(.TENTH_CYCLES(TC)) u_dut (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .present_value(present_value),
    .manipulated_output(manipulated_output), .output_strobe(output_strobe));
  plc_plant u_plant (
    .clk(clk), .srst(srst), .level(level), .manipulated_output(manipulated_output), .output_strobe(output_strobe),
    .present_value(present_value), .actuated(actuated), .actuator_value(actuator_value));
  // ====
  // Checking and bus tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, d);
    check("write error flag", 32'h0, {31'h0, er});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    check("read data", e, rd);
    check("error flag", {31'h0, ee}, {31'h0, er});
  endtask
  // Stops first so that limits never change under a running sample
  task automatic cfg(input int ctl, input int b, input int lo, input int up, input int iv);
    ivl = iv;
    wr(`PLC_ADDR_CTRL, 0);
    wr(`PLC_ADDR_BIAS, b);
    wr(`PLC_ADDR_LOWER, lo);
    wr(`PLC_ADDR_UPPER, up);
    wr(`PLC_ADDR_INTERVAL, iv);
    wr(`PLC_ADDR_CTRL, ctl);
  endtask
  task automatic smp(input int s, input int p, input int e, input bit first);
    int n;
    wr(`PLC_ADDR_SET, s);
    level <= p[15:0];
    exp_q.push_back(e[15:0]);
    n = 0;
    while (exp_q.size() != 0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      summarize();
    end
    if (!first) check("sample spacing", ivl * TC, last_gap);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  function automatic int clampv(input int v, input int lo, input int up);
    return (v < lo) ? lo : ((v > up) ? up : v);
  endfunction
  always @(posedge clk) begin
    gap <= actuated ? 1 : gap + 1;
    if (actuated) begin
      last_gap <= gap;
      if (exp_q.size() == 0) check("unexpected output", 32'h0, 32'h1);
      else check("manipulated output", {16'h0, exp_q.pop_front()}, {16'h0, actuator_value});
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    void'($urandom(11588));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) rdc(ra[i], rv[i], i == 7);
    wr(`PLC_ADDR_UPPER, 5000);
    rdc(`PLC_ADDR_UPPER, 32'hfa0, 1'b0);
    wr(`PLC_ADDR_INTERVAL, 200);
    rdc(`PLC_ADDR_INTERVAL, 32'h64, 1'b0);
    done("registers");
    for (int r = 0; r < 2; r++) begin
      bias = $urandom % 201;
      cfg(r ? 5'h09 : 5'h01, bias, 300, 3500, 2 - r);
      for (int i = 0; i < 4; i++) begin
        sv = $urandom % 4001;
        pv = $urandom % 4001;
        smp(sv, pv, clampv((r ? pv - sv : sv - pv) + bias, 300, 3500), i == 0);
      end
      done(r ? "reverse" : "forward");
    end
    cfg(5'h07, 0, 300, 3500, 1);
    smp(2000, 1000, 3500, 1'b1);
    smp(1000, 2000, 300, 1'b0);
    smp(1500, 1500, 300, 1'b0);
    done("on off");
    wr(`PLC_ADDR_MANUAL, 1234);
    cfg(5'h17, 0, 300, 3500, 1);
    smp(2000, 1000, 1234, 1'b1);
    smp(100, 3000, 1234, 1'b0);
    done("manual");
    wr(`PLC_ADDR_ISPAN, 1);
    wr(`PLC_ADDR_DSPAN, 3);
    cfg(5'h03, 0, 0, 4000, 1);
    for (int i = 1; i < 4; i++) smp(1500, 1000, 500 * i, i == 1);
    done("integral");
    cfg(5'h05, 0, 0, 4000, 1);
    smp(1500, 1100, 1600, 1'b1);
    smp(1500, 1100, 2300, 1'b0);
    // Status, output and captured sample read back while running and unsaturated
    rdc(`PLC_ADDR_STATUS, 32'h1, 1'b0);
    rdc(`PLC_ADDR_OUTPUT, 32'h8fc, 1'b0);
    rdc(`PLC_ADDR_PV, 32'h44c, 1'b0);
    done("three term");
    summarize();
  end
endmodule
